// *** hdl/swm_defines.vh ***
`ifndef SWM_DEFINES_VH
`define SWM_DEFINES_VH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------
`define SWM_IDX_CONTROL 8'h0D
`define SWM_IDX_STATUS 8'h0E
`define SWM_IDX_PINS 8'h10
`define SWM_IDX_W 8

// ----------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------
`define SWM_CTL_SIE 7
`define SWM_CTL_OIE 6
`define SWM_CTL_WM_HI 5
`define SWM_CTL_WM_LO 4
`define SWM_CTL_CS_HI 3
`define SWM_CTL_CS_LO 2
`define SWM_CTL_CLK 1
`define SWM_CTL_TC 0
`define SWM_CTL_RESET 8'h00

// ----------------------------------------------------------------
// Status register fields.
// ----------------------------------------------------------------
`define SWM_STA_SIF 7
`define SWM_STA_OIF 6
`define SWM_STA_CNT_HI 3
`define SWM_STA_CNT_LO 0
`define SWM_STA_RESET 8'h00

// ----------------------------------------------------------------
// Pin register fields: port bits, direction bits, global enable.
// ----------------------------------------------------------------
`define SWM_PIN_PORT_LO 0
`define SWM_PIN_DIR_LO 4
`define SWM_PIN_GIE 7
`define SWM_PIN_RESET 8'h00

// ----------------------------------------------------------------
// Wire modes and pin positions.
// ----------------------------------------------------------------
`define SWM_WM_OFF 2'b00
`define SWM_WM_THREE 2'b01
`define SWM_WM_TWO_HOLD 2'b11
`define SWM_PIN_DO 0
`define SWM_PIN_SDA 1
`define SWM_PIN_SCL 2
`define SWM_CNT_RESET 4'h0

`endif

// *** hdl/swm_sync.v ***
`timescale 1ns/100ps
module swm_sync (
    input wire pclk,
    input wire presetn,
    input wire pin_raw,
    output reg level_r
);
reg s1_r;
reg s2_r;
reg s3_r;

// ----------------------------------------------------------------
// Three stages; a change counts once the last two agree.
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        s3_r <= 1'b1;
        level_r <= 1'b1;
    end else begin
        s1_r <= pin_raw;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
end
endmodule // swm_sync

// *** hdl/swm_counter.v ***
`timescale 1ns/100ps
`include "swm_defines.vh"
module swm_counter #(
    parameter WIDTH = 4
) (
    input wire pclk,
    input wire presetn,
    input wire inc,
    input wire load,
    input wire [WIDTH-1:0] load_val,
    output reg [WIDTH-1:0] count_r,
    output wire wrap
);
// A write from software wins over a clock in the same cycle.
assign wrap = inc && !load && (&count_r);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        count_r <= {WIDTH{1'b0}};
    end else if (load) begin
        count_r <= load_val;
    end else if (inc) begin
        count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end
endmodule // swm_counter

// *** hdl/swm_ctrl.v ***
// Notes on behaviour
// - Counter advances once per selected clock event.
// - External source plus select: toggle writes clock.
// - External clock drives counter with outputs off.
// - Control register layout, strobes write-only, reset zero.
// - Start enable lets start flag request interrupt.
// - Overflow enable lets overflow flag request interrupt.
// - Pending flag requests immediately once enabled.
// - Wire mode changes outputs only, inputs unchanged.
// - Mode zero: outputs and hold off; external SCL edges still set start flag.
// - Three-wire: data bit replaces port output value.
// - Three-wire: input and clock pins act normally.
// - Two-wire: open-collector lines enabled by direction.
// - SCL pulled low if port zero or held.
// - Start detection holds SCL until flag cleared.
// - Mode three also holds SCL after overflow.
// - Clock source set by select field and strobe.
// - Start flag clears only on written one.
// - Overflow flag sets when counter wraps to zero.
// - Overflow flag clear also releases overflow hold.
// - Select cleared: strobe clocks shift and counter.
`timescale 1ns/100ps
`include "swm_defines.vh"
module swm_ctrl #(
    parameter CNT_W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    input wire [2:0] pin_in,
    output reg [2:0] pin_out,
    output reg [2:0] pin_oe_n,
    output reg [2:0] pin_pullup,
    input wire data_msb,
    input wire timer_match,
    input wire start_detect,
    output reg shift_clk,
    output reg start_irq,
    output reg overflow_irq,
    output wire sda_level,
    output wire scl_level
);

// ----------------------------------------------------------------
// Register state.
// ----------------------------------------------------------------
reg start_ie_r;
reg ovf_ie_r;
reg [1:0] wire_mode_r;
reg [1:0] clk_src_r;
reg clk_sel_r;
reg start_flag_r;
reg ovf_flag_r;
reg [2:0] port_r;
reg [2:0] dir_r;
reg gie_r;
reg scl_prev_r;
wire [CNT_W-1:0] count;
wire cnt_wrap;

// ----------------------------------------------------------------
// Register select codes.
// ----------------------------------------------------------------
localparam [1:0] SEL_NONE = 2'd0;
localparam [1:0] SEL_CTL = 2'd1;
localparam [1:0] SEL_STA = 2'd2;
localparam [1:0] SEL_PIN = 2'd3;

// ----------------------------------------------------------------
// APB decode.
// ----------------------------------------------------------------
function [1:0] reg_sel;
    input [31:0] addr;
    begin
        if (addr[1:0] != 2'b00) begin
            reg_sel = SEL_NONE;
        end else if (addr[31:2] == {22'h0, `SWM_IDX_CONTROL}) begin
            reg_sel = SEL_CTL;
        end else if (addr[31:2] == {22'h0, `SWM_IDX_STATUS}) begin
            reg_sel = SEL_STA;
        end else if (addr[31:2] == {22'h0, `SWM_IDX_PINS}) begin
            reg_sel = SEL_PIN;
        end else begin
            reg_sel = SEL_NONE;
        end
    end
endfunction

wire [1:0] sel = reg_sel(paddr);
wire access = psel && penable;
wire wr_low = access && pwrite && pstrb[0];
wire wr_ctl = wr_low && (sel == SEL_CTL);
wire wr_sta = wr_low && (sel == SEL_STA);
wire wr_pin = wr_low && (sel == SEL_PIN);

// Zero wait states keep software strobes aligned to one bus cycle.
assign pready = 1'b1;
assign pslverr = access && (sel == SEL_NONE);

// ----------------------------------------------------------------
// Input synchronisers.
// ----------------------------------------------------------------
swm_sync u_sync_sda (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(pin_in[`SWM_PIN_SDA]),
    .level_r(sda_level)
);

swm_sync u_sync_scl (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(pin_in[`SWM_PIN_SCL]),
    .level_r(scl_level)
);

// Edges are taken from the synchronised level in every wire mode.
wire scl_rise = scl_level && !scl_prev_r;
wire scl_fall = !scl_level && scl_prev_r;
wire scl_edge = scl_rise || scl_fall;

// ----------------------------------------------------------------
// Clock source selection.
// ----------------------------------------------------------------
wire soft_strobe = wr_ctl && pwdata[`SWM_CTL_CLK];
wire tog_strobe = wr_ctl && pwdata[`SWM_CTL_TC];
wire ext_src = clk_src_r[1];

// Select and toggle written together clock at once, so a master's first
// toggle is not lost.
wire tog_sel = wr_ctl ? pwdata[`SWM_CTL_CLK] : clk_sel_r;
reg cnt_clk;
reg shift_clk_nxt;

always @* begin
    cnt_clk = 1'b0;
    shift_clk_nxt = 1'b0;
    case (clk_src_r)
    2'b00: begin
        cnt_clk = soft_strobe;
        shift_clk_nxt = soft_strobe;
    end
    2'b01: begin
        cnt_clk = timer_match;
        shift_clk_nxt = timer_match;
    end
    2'b10: begin
        shift_clk_nxt = scl_rise;
        cnt_clk = tog_sel ? tog_strobe : scl_edge;
    end
    2'b11: begin
        shift_clk_nxt = scl_fall;
        cnt_clk = tog_sel ? tog_strobe : scl_edge;
    end
    default: begin
        cnt_clk = 1'b0;
        shift_clk_nxt = 1'b0;
    end
    endcase
end

// ----------------------------------------------------------------
// Transfer counter.
// ----------------------------------------------------------------
swm_counter #(
    .WIDTH(CNT_W)
) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .inc(cnt_clk),
    .load(wr_sta),
    .load_val(pwdata[CNT_W-1:0]),
    .count_r(count),
    .wrap(cnt_wrap)
);

// ----------------------------------------------------------------
// Flags.
// ----------------------------------------------------------------
wire two_wire = wire_mode_r[1];
wire edge_start = !two_wire && ext_src && !clk_sel_r && scl_edge;
wire start_set = (two_wire && start_detect) || edge_start;
// Only a written one clears a flag; a zero leaves it pending.
wire start_clr = wr_sta && pwdata[`SWM_STA_SIF];
wire ovf_clr = wr_sta && pwdata[`SWM_STA_OIF];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        start_flag_r <= 1'b0;
        ovf_flag_r <= 1'b0;
        scl_prev_r <= 1'b1;
        shift_clk <= 1'b0;
    end else begin
        scl_prev_r <= scl_level;
        shift_clk <= shift_clk_nxt;
        // A new start event in the clearing cycle keeps the start flag set; a status write blocks a wrap.
        if (start_set) begin
            start_flag_r <= 1'b1;
        end else if (start_clr) begin
            start_flag_r <= 1'b0;
        end
        if (cnt_wrap) begin
            ovf_flag_r <= 1'b1;
        end else if (ovf_clr) begin
            ovf_flag_r <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Control and pin registers.
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        start_ie_r <= 1'b0;
        ovf_ie_r <= 1'b0;
        wire_mode_r <= 2'b00;
        clk_src_r <= 2'b00;
        clk_sel_r <= 1'b0;
        port_r <= 3'h0;
        dir_r <= 3'h0;
        gie_r <= 1'b0;
    end else begin
        if (wr_ctl) begin
            start_ie_r <= pwdata[`SWM_CTL_SIE];
            ovf_ie_r <= pwdata[`SWM_CTL_OIE];
            wire_mode_r <= pwdata[`SWM_CTL_WM_HI:`SWM_CTL_WM_LO];
            clk_src_r <= pwdata[`SWM_CTL_CS_HI:`SWM_CTL_CS_LO];
            clk_sel_r <= pwdata[`SWM_CTL_CLK];
        end
        if (wr_pin) begin
            port_r <= pwdata[`SWM_PIN_PORT_LO+2:`SWM_PIN_PORT_LO];
            dir_r <= pwdata[`SWM_PIN_DIR_LO+2:`SWM_PIN_DIR_LO];
            gie_r <= pwdata[`SWM_PIN_GIE];
        end else if (tog_strobe) begin
            // Toggling ignores direction, as a master clock source.
            port_r[`SWM_PIN_SCL] <= ~port_r[`SWM_PIN_SCL];
        end
    end
end

// ----------------------------------------------------------------
// Read data, captured in the setup cycle.
// ----------------------------------------------------------------
reg [7:0] rd_byte;

always @* begin
    case (sel)
    SEL_CTL: rd_byte = {start_ie_r, ovf_ie_r, wire_mode_r, clk_src_r,
                        2'b00};
    SEL_STA: rd_byte = {start_flag_r, ovf_flag_r, 2'b00, count};
    SEL_PIN: rd_byte = {gie_r, dir_r, 1'b0, port_r};
    default: rd_byte = 8'h00;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, rd_byte};
    end
end

// ----------------------------------------------------------------
// Interrupt requests: plain level of flag, enable and global enable.
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        start_irq <= 1'b0;
        overflow_irq <= 1'b0;
    end else begin
        start_irq <= start_flag_r && start_ie_r && gie_r;
        overflow_irq <= ovf_flag_r && ovf_ie_r && gie_r;
    end
end

// ----------------------------------------------------------------
// Pin drivers.
// ----------------------------------------------------------------
wire start_hold = two_wire && start_flag_r;
wire ovf_hold = (wire_mode_r == `SWM_WM_TWO_HOLD) && ovf_flag_r;
reg [2:0] out_nxt;
reg [2:0] oe_n_nxt;
reg [2:0] pu_nxt;
integer i;

always @* begin
    // General purpose behaviour is the base for every pin.
    for (i = 0; i < 3; i = i + 1) begin
        out_nxt[i] = port_r[i];
        oe_n_nxt[i] = ~dir_r[i];
        pu_nxt[i] = ~dir_r[i] & port_r[i];
    end
    case (wire_mode_r)
    `SWM_WM_OFF: begin
        out_nxt = port_r;
    end
    `SWM_WM_THREE: begin
        out_nxt[`SWM_PIN_DO] = data_msb;
    end
    default: begin
        // Open collector: drive only a low, release otherwise.
        out_nxt[`SWM_PIN_SDA] = 1'b0;
        out_nxt[`SWM_PIN_SCL] = 1'b0;
        oe_n_nxt[`SWM_PIN_SDA] = ~(dir_r[`SWM_PIN_SDA] &
            (~data_msb | ~port_r[`SWM_PIN_SDA]));
        oe_n_nxt[`SWM_PIN_SCL] = ~(dir_r[`SWM_PIN_SCL] &
            (~port_r[`SWM_PIN_SCL] | start_hold |
             ovf_hold));
        pu_nxt[`SWM_PIN_SDA] = 1'b0;
        pu_nxt[`SWM_PIN_SCL] = 1'b0;
    end
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        // Every line starts released with its pull-up off.
        pin_out <= 3'h0;
        pin_oe_n <= 3'h7;
        pin_pullup <= 3'h0;
    end else begin
        pin_out <= out_nxt;
        pin_oe_n <= oe_n_nxt;
        pin_pullup <= pu_nxt;
    end
end

endmodule // swm_ctrl

// *** test/swm_ctrl_assertions.sv ***
`timescale 1ns/100ps
module swm_ctrl_chk #(parameter CNT_W = 4) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pslverr,
    input wire [2:0] pin_out,
    input wire [2:0] pin_oe_n,
    input wire [2:0] pin_pullup,
    input wire data_msb,
    input wire timer_match,
    input wire start_detect,
    input wire shift_clk,
    input wire start_irq,
    input wire overflow_irq
);
    // ------------------------------------------------------------
    // Shadow registers rebuilt from bus writes.
    // ------------------------------------------------------------
    reg [7:0] ctl_r;
    reg [7:0] pin_r;
    wire wr = psel && penable && pwrite && pstrb[0];
    wire acc = psel && penable;
    wire mapped = paddr == 32'h34 || paddr == 32'h38 || paddr == 32'h40;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= 8'h00;
            pin_r <= 8'h00;
        end else if (wr && paddr == 32'h34) begin
            ctl_r <= pwdata[7:0];
            pin_r[2] <= pin_r[2] ^ pwdata[0];
        end else if (wr && paddr == 32'h40) begin
            pin_r <= pwdata[7:0];
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence strobe_s;
        wr && paddr == 32'h34 && pwdata[3:1] == 3'h1 && ctl_r[3:2] == 2'h0;
    endsequence
    a_slverr_map: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_strobe_shift: assert property (strobe_s |-> ##[1:2] shift_clk)
        else $error("strobe gave no shift");
    a_timer_shift: assert property (
        ctl_r[3:2] == 2'h1 && timer_match |-> ##[1:2] shift_clk)
        else $error("timer match gave no shift");
    a_mode_off: assert property (
        ctl_r[5:4] == 2'h0 && $past(ctl_r[5:4]) == 2'h0 |->
        pin_oe_n == ~$past(pin_r[6:4]) && pin_out == $past(pin_r[2:0]))
        else $error("mode zero pins differ from port");
    a_three_do: assert property (
        ctl_r[5:4] == 2'h1 && $past(ctl_r[5:4]) == 2'h1 |->
        pin_out == {$past(pin_r[2:1]), $past(data_msb)})
        else $error("three-wire output wrong");
    a_two_pull: assert property (
        ctl_r[5] && $past(ctl_r[5]) |-> pin_pullup[2:1] == 2'h0)
        else $error("pull-up on in two-wire");
    a_sda_oc: assert property (ctl_r[5] && $past(ctl_r[5]) |->
        !pin_out[1] && pin_oe_n[1] == !($past(pin_r[5]) &&
        !($past(data_msb) && $past(pin_r[1]))))
        else $error("data line drive wrong");
    a_start_hold: assert property (
        ctl_r[5] && pin_r[6] && start_detect |-> ##[1:3] !pin_oe_n[2])
        else $error("clock not held after start");
    a_start_gate: assert property (
        start_irq |-> $past(ctl_r[7]) && $past(pin_r[7]))
        else $error("start request not enabled");
    a_ovf_gate: assert property (
        overflow_irq |-> $past(ctl_r[6]) && $past(pin_r[7]))
        else $error("overflow request not enabled");
endmodule // swm_ctrl_chk

bind swm_ctrl swm_ctrl_chk #(.CNT_W(CNT_W)) chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
    .data_msb(data_msb), .timer_match(timer_match),
    .start_detect(start_detect), .shift_clk(shift_clk),
    .start_irq(start_irq), .overflow_irq(overflow_irq));

// *** test/swm_peer.sv ***
`timescale 1ns/100ps
module swm_peer (
    input wire go,
    input wire [7:0] tx_byte,
    output reg scl_low,
    output reg sda_low,
    output reg busy
);
    // ------------------------------------------------------------
    // Start, eight bits with a 64 ns clock, stop; idle lines released.
    // ------------------------------------------------------------
    integer i;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        busy = 1'b0;
    end
    always @(posedge go) begin
        busy = 1'b1;
        #2;
        sda_low = 1'b1;
        #32;
        for (i = 7; i >= 0; i = i - 1) begin
            scl_low = 1'b1;
            #16;
            sda_low = ~tx_byte[i];
            #16;
            scl_low = 1'b0;
            #32;
        end
        sda_low = 1'b1;
        #16;
        sda_low = 1'b0;
        busy = 1'b0;
    end
endmodule // swm_peer

// *** test/tb.sv ***
`timescale 1ns/100ps
`include "swm_defines.vh"
module tb;
    localparam [7:0] CT = `SWM_IDX_CONTROL;
    localparam [7:0] ST = `SWM_IDX_STATUS;
    localparam [7:0] PN = `SWM_IDX_PINS;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    reg pwrite = 1'b0, data_msb = 1'b0, timer_match = 1'b0;
    reg start_detect = 1'b0, go = 1'b0, slv;
    reg [31:0] paddr = 32'h0, pwdata = 32'h0;
    reg [3:0] pstrb = 4'hF;
    reg [7:0] rd, e, tx = 8'h00;
    wire pready, pslverr, shift_clk, start_irq, overflow_irq;
    wire scl_low, sda_low, busy;
    wire sda_level, scl_level;
    wire [31:0] prdata;
    wire [2:0] pin_in, pin_out, pin_oe_n, pin_pullup;
    integer errors = 0, checks_done = 0, i, k;
    // Lines are pulled up; any party may pull them low.
    assign pin_in[0] = pin_oe_n[0] | pin_out[0];
    assign pin_in[1] = !sda_low && (pin_oe_n[1] || pin_out[1]);
    assign pin_in[2] = !scl_low && (pin_oe_n[2] || pin_out[2]);
    swm_ctrl #(.CNT_W(4)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
        .data_msb(data_msb), .timer_match(timer_match),
        .start_detect(start_detect), .shift_clk(shift_clk),
        .start_irq(start_irq), .overflow_irq(overflow_irq),
        .sda_level(sda_level), .scl_level(scl_level));
    swm_peer peer_u (.go(go), .tx_byte(tx), .scl_low(scl_low),
        .sda_low(sda_low), .busy(busy));
    // ------------------------------------------------------------
    // Bus, comparison and reporting tasks.
    // ------------------------------------------------------------
    initial begin
        forever #4 pclk = ~pclk;
    end
    task conclude;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input [7:0] s, input [7:0] x);
        checks_done = checks_done + 1;
        if (s !== x) begin
            errors = errors + 1;
            $display("Error %0t: saw %h want %h", $time, s, x);
        end
    endtask
    task apb(input w, input [7:0] idx, input [7:0] d);
        integer n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata[7:0];
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors = errors + 1;
            conclude;
        end
    endtask
    task wr(input [7:0] idx, input [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task rc(input [7:0] idx, input [7:0] x);
        apb(1'b0, idx, 8'h00);
        chk(rd, x);
    endtask
    task look(input integer n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // Expected two-wire enables: low drives the line low.
    function [7:0] oe2(input [6:0] pr, input msb, input hold);
        oe2 = {5'h0, ~(pr[6] & (~pr[2] | hold)),
            ~(pr[5] & (~msb | ~pr[1])), ~pr[4]};
    endfunction
    initial begin
        k = $urandom(92);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(CT, 8'h00);
        rc(ST, 8'h00);
        chk({5'h0, pin_oe_n}, 8'h07);
        apb(1'b0, 8'h0C, 8'h00);
        chk({7'h0, slv}, 8'h01);
        k = 1 + $urandom % 14;
        for (i = 0; i < k; i = i + 1) wr(CT, 8'h02);
        rc(ST, k[7:0]);
        rc(CT, 8'h00);
        wr(CT, 8'h04);
        wr(ST, 8'h00);
        k = 1 + $urandom % 14;
        for (i = 0; i < k; i = i + 1) begin
            @(posedge pclk);
            timer_match <= 1'b1;
            @(posedge pclk);
            timer_match <= 1'b0;
        end
        rc(ST, k[7:0]);
        wr(CT, 8'h0A);
        wr(ST, 8'h00);
        k = 1 + $urandom % 7;
        for (i = 0; i < k; i = i + 1) wr(CT, 8'h0B);
        rc(ST, k[7:0]);
        rc(PN, {5'h0, k[0], 2'h0});
        wr(CT, 8'h00);
        wr(ST, 8'h0F);
        wr(CT, 8'h02);
        rc(ST, 8'h40);
        wr(ST, 8'h00);
        rc(ST, 8'h40);
        wr(CT, 8'h40);
        look(2);
        chk({7'h0, overflow_irq}, 8'h00);
        wr(PN, 8'h80);
        look(2);
        chk({7'h0, overflow_irq}, 8'h01);
        wr(ST, 8'h40);
        look(2);
        chk({7'h0, overflow_irq}, 8'h00);
        wr(CT, 8'h08);
        wr(ST, 8'hC0);
        tx = $urandom;
        @(posedge pclk);
        go <= 1'b1;
        look(2);
        for (i = 0; i < 200 && busy !== 1'b0; i = i + 1) @(posedge pclk);
        go <= 1'b0;
        if (busy !== 1'b0) begin
            errors = errors + 1;
            conclude;
        end
        look(10);
        rc(ST, 8'hC0);
        wr(ST, 8'hC0);
        wr(CT, 8'hA0);
        wr(PN, 8'hE6);
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge pclk);
            data_msb <= i[0];
            look(6);
            chk({5'h0, pin_oe_n}, oe2(7'h66, i[0], 1'b0));
            chk({5'h0, pin_pullup}, 8'h00);
            chk({7'h0, sda_level}, {7'h0, i[0]});
        end
        @(posedge pclk);
        start_detect <= 1'b1;
        @(posedge pclk);
        start_detect <= 1'b0;
        look(3);
        chk({5'h0, pin_oe_n}, oe2(7'h66, 1'b1, 1'b1));
        chk({7'h0, start_irq}, 8'h01);
        look(3);
        chk({7'h0, scl_level}, 8'h00);
        wr(ST, 8'h00);
        look(2);
        chk({5'h0, pin_oe_n}, oe2(7'h66, 1'b1, 1'b1));
        wr(ST, 8'h80);
        look(2);
        chk({5'h0, pin_oe_n}, oe2(7'h66, 1'b1, 1'b0));
        chk({7'h0, start_irq}, 8'h00);
        for (i = 0; i < 2; i = i + 1) begin
            wr(ST, 8'h0F);
            wr(CT, i[0] ? 8'h22 : 8'h32);
            look(2);
            chk({5'h0, pin_oe_n}, oe2(7'h66, 1'b1, !i[0]));
            wr(ST, 8'h40);
            look(2);
            chk({5'h0, pin_oe_n}, oe2(7'h66, 1'b1, 1'b0));
        end
        wr(CT, 8'h10);
        wr(PN, 8'h14);
        for (i = 0; i < 4; i = i + 1) begin
            e = $urandom;
            @(posedge pclk);
            data_msb <= e[0];
            look(3);
            chk({pin_pullup[2], pin_oe_n, pin_out, 1'b0},
                {1'b1, 3'h6, 2'h2, e[0], 1'b0});
        end
        conclude;
    end
endmodule // tb
